// *** logic/psv_pkg.sv ***
// Package: constants, register map and types of the program sequencer
// Function
// R1 - Full stack: flag recorded, acknowledge withheld
// R2 - Withheld interrupt serviced after return pops
// R3 - Call on full stack still executes, overflows
// R4 - ALU writes result and updates status flags
// R5 - Program memory is 4K words of 15 bits
// R6 - Reset loads program counter with 000H
// R7 - USB interrupt vectors to 004H
// R8 - External falling edge vectors to 008H
// R9 - Timer 0 overflow vectors to 00CH
// R10 - Serial interface A done vectors to 010H
// R11 - Serial interface B done vectors to 014H
// R12 - Timer 1 overflow vectors to 018H
// R13 - Table pointer low gives low address byte
// R14 - Current page read uses PC bits 11..8
// R15 - Last page read forces page F00H
// R16 - Low byte to destination, high to latch
// R17 - Enabled high pointer selects any page
// R18 - Six hidden stack levels, pointer reset top
// R19 - Call and acknowledge push, returns pop
// R20 - Table read takes two cycles
// R21 - Lowest pending vector acknowledged first
package psv_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PC_W        = 12;
    localparam int PM_DEPTH    = 4096;
    localparam int PM_W        = 15;
    localparam int STACK_DEPTH = 6;
    localparam int N_INT       = 6;

    // ------------------------------------------------------------
    // Vectors, indexed by interrupt number (lowest vector first)
    // ------------------------------------------------------------
    localparam logic [11:0] VEC_RESET = 12'h000;
    localparam logic [11:0] VEC_TABLE [N_INT] = '{12'h004, 12'h008, 12'h00C,
                                                  12'h010, 12'h014, 12'h018};
    localparam int INT_USB  = 0;
    localparam int INT_EXT  = 1;
    localparam int INT_TMR0 = 2;
    localparam int INT_SER_A = 3;
    localparam int INT_SER_B = 4;
    localparam int INT_TMR1 = 5;
    localparam logic [3:0] LAST_PAGE = 4'hF;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CMD      = 8'h08;
    localparam logic [7:0] REG_TBL_LOW  = 8'h0C;
    localparam logic [7:0] REG_TBL_HIGH = 8'h10;
    localparam logic [7:0] REG_TBL_RES  = 8'h14;
    localparam logic [7:0] REG_INT_FLAG = 8'h18;
    localparam logic [7:0] REG_INT_EN   = 8'h1C;
    localparam logic [7:0] REG_PM_ADDR  = 8'h20;
    localparam logic [7:0] REG_PM_DATA  = 8'h24;
    localparam logic [7:0] REG_ACC      = 8'h28;

    // Field positions and control register reset value
    localparam int CTRL_HP_EN   = 0;
    localparam int CTRL_GIE     = 1;
    localparam int CMD_OP_LSB   = 16;
    localparam int STAT_OVF     = 4;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP, OP_JMP, OP_CALL, OP_RETURN, OP_INT_RETURN, OP_TBL_CUR, OP_TBL_LAST,
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_LOAD_PC_LOW
    } psv_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_BRANCH, ST_TBL} psv_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } psv_aphase_t;

    typedef struct packed {
        psv_op_t     op;
        logic [11:0] arg;
    } psv_cmd_t;

endpackage

// *** logic/psv_prog_mem.sv ***
// Program memory: 4K x 15 words, one write port, registered read port
module psv_prog_mem import psv_pkg::*; (
    // Clock
    input  wire logic             sys_clk,
    // Write port
    input  wire logic             wrEn,
    input  wire logic [PC_W-1:0]  wrAddr,
    input  wire logic [PM_W-1:0]  wrData,
    // Read port
    input  wire logic [PC_W-1:0]  rdAddr,
    output logic      [PM_W-1:0]  rdData
);
    logic [PM_W-1:0] mem [PM_DEPTH];  // R5

    // Contents are not reset; software loads them before use
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// *** logic/psv_ret_stack.sv ***
// Return stack: six hidden levels of program counter
module psv_ret_stack import psv_pkg::*; (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Push and pop
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [PC_W-1:0]  pushData,
    // State
    output logic      [PC_W-1:0]  top,
    output logic      [2:0]       level,
    output logic                  full
);
    logic [PC_W-1:0] slot_r [STACK_DEPTH];
    logic [PC_W-1:0] slot_nxt [STACK_DEPTH];
    logic [2:0]      level_r;
    logic [2:0]      level_nxt;

    localparam logic [2:0] LVL_FULL = 3'(STACK_DEPTH);

    always_comb begin
        slot_nxt  = slot_r;
        level_nxt = level_r;
        if (push) begin  // R19
            if (level_r < LVL_FULL) begin
                slot_nxt[level_r] = pushData;
                level_nxt         = level_r + 3'h1;
            end else begin
                // Overflow: newest entry clobbers the top, the entry that was on top is lost
                slot_nxt[STACK_DEPTH-1] = pushData;  // R3
            end
        end else if (pop && level_r != 3'h0) begin
            level_nxt = level_r - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            level_r <= 3'h0;  // R18
        end else begin
            level_r <= level_nxt;
        end
        slot_r <= slot_nxt;
    end

    assign top   = (level_r == 3'h0) ? slot_r[0] : slot_r[level_r - 3'h1];
    assign level = level_r;
    assign full  = (level_r == LVL_FULL);
endmodule

// *** logic/psv_sequencer.sv ***
// Program sequencer: vectors, interrupt acknowledge, table reads, AHB-Lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
module psv_sequencer import psv_pkg::*; (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic      [31:0]      hrdata,
    // Interrupt sources
    input  wire logic             usbIrq,
    input  wire logic             extIntN,
    input  wire logic             tmr0Ovf,
    input  wire logic             serialIfaceADone,
    input  wire logic             serialIfaceBDone,
    input  wire logic             tmr1Ovf,
    // Sequencer state
    output logic      [PC_W-1:0]  pcOut,
    output logic                  intAckPulse,
    output logic      [2:0]       ackIndex
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    psv_aphase_t aph_r, aph_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        addrPhase;
    logic        busWr;

    // Core state
    psv_state_t       state_r, state_nxt;
    psv_cmd_t         cmd_r, cmd_nxt;
    logic             cmdValid_r, cmdValid_nxt;
    logic [PC_W-1:0]  pc_r, pc_nxt;
    logic [7:0]       acc_r, acc_nxt;
    logic             carry_r, carry_nxt, zero_r, zero_nxt;
    logic [7:0]       tblLow_r, tblLow_nxt, tblHigh_r, tblHigh_nxt;
    logic [7:0]       tblDest_r, tblDest_nxt, tableHighLatch_r, tableHighLatch_nxt;
    logic [N_INT-1:0] intFlag_r, intFlag_nxt, intEn_r, intEn_nxt;
    logic [1:0]       ctrl_r, ctrl_nxt;
    logic             ovf_r, ovf_nxt, extPrev_r, ack_r, ack_nxt;
    logic [2:0]       ackIdx_r, ackIdx_nxt;
    logic [PC_W-1:0]  pmAddr_r, pmAddr_nxt;

    // Stack and memory hookup
    logic             stkPush, stkPop, stkFull;
    logic [PC_W-1:0]  stkPushData, stkTop, pmRaddr;
    logic [2:0]       stkLevel;
    logic [PM_W-1:0]  pmRdata;
    logic             pmWe;

    // Decode helpers
    logic [N_INT-1:0] events, pending, ackHot;
    logic [2:0]       prioIdx;
    logic             canAck;
    logic [8:0]       aluSum;

    assign addrPhase = hsel && htrans[1] && hready;
    assign busWr     = aph_r.valid && aph_r.write;

    always_comb begin
        aph_nxt    = '{valid: addrPhase, write: hwrite, addr: haddr[7:0]};
        hrdata_nxt = hrdata_r;
        if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL:     hrdata_nxt = {30'h0, ctrl_r};
                REG_STATUS:   hrdata_nxt = {4'h0, pc_r, 5'h0, stkLevel, 3'h0,
                                            ovf_r, stkFull,
                                            (state_r != ST_IDLE) || cmdValid_r,
                                            zero_r, carry_r};
                REG_CMD:      hrdata_nxt = {12'h0, cmd_r.op, 4'h0, cmd_r.arg};
                REG_TBL_LOW:  hrdata_nxt = {24'h0, tblLow_r};
                REG_TBL_HIGH: hrdata_nxt = {24'h0, tblHigh_r};
                REG_TBL_RES:  hrdata_nxt = {16'h0, tableHighLatch_r, tblDest_r};
                REG_INT_FLAG: hrdata_nxt = {26'h0, intFlag_r};
                REG_INT_EN:   hrdata_nxt = {26'h0, intEn_r};
                REG_PM_ADDR:  hrdata_nxt = {20'h0, pmAddr_r};
                REG_ACC:      hrdata_nxt = {24'h0, acc_r};
                // Unmapped and write-only addresses read zero with OKAY
                default:      hrdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            aph_r     <= '0;
            hrdata_r  <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            aph_r     <= aph_nxt;
            hrdata_r  <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    assign hrdata = hrdata_r;

    // ------------------------------------------------------------
    // Interrupt selection
    // ------------------------------------------------------------
    assign events = {tmr1Ovf, serialIfaceBDone, serialIfaceADone, tmr0Ovf,
                     extPrev_r && !extIntN, usbIrq};  // R8
    assign pending = intFlag_r & intEn_r;

    always_comb begin
        prioIdx = 3'h0;
        for (int i = N_INT - 1; i >= 0; i--) begin
            if (pending[i]) begin
                prioIdx = 3'(i);  // R21
            end
        end
    end

    // Full stack withholds acknowledge; a pop reopens it next cycle
    assign canAck = ctrl_r[CTRL_GIE] && (|pending) && !stkFull;  // R1 R2

    // Table address: low byte always from the low pointer
    always_comb begin
        if (cmd_r.op == OP_TBL_CUR) begin
            pmRaddr = {pc_r[11:8], tblLow_r};  // R13 R14
        end else if (ctrl_r[CTRL_HP_EN]) begin
            pmRaddr = {tblHigh_r[3:0], tblLow_r};  // R17
        end else begin
            pmRaddr = {LAST_PAGE, tblLow_r};  // R15
        end
    end

    // ------------------------------------------------------------
    // Core sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;           cmd_nxt = cmd_r;
        cmdValid_nxt = cmdValid_r;     pc_nxt = pc_r;
        acc_nxt = acc_r;               carry_nxt = carry_r;
        zero_nxt = zero_r;             tblLow_nxt = tblLow_r;
        tblHigh_nxt = tblHigh_r;       tblDest_nxt = tblDest_r;
        tableHighLatch_nxt = tableHighLatch_r;
        intEn_nxt = intEn_r;           ctrl_nxt = ctrl_r;
        ovf_nxt = ovf_r;               ack_nxt = 1'b0;
        ackIdx_nxt = ackIdx_r;         pmAddr_nxt = pmAddr_r;
        stkPush = 1'b0;                stkPop = 1'b0;
        stkPushData = pc_r;            ackHot = '0;
        aluSum = 9'h0;                 pmWe = 1'b0;
        intFlag_nxt = intFlag_r;

        if (busWr) begin
            case (aph_r.addr)
                REG_CTRL:     ctrl_nxt = hwdata[1:0];
                REG_TBL_LOW:  tblLow_nxt = hwdata[7:0];
                REG_TBL_HIGH: tblHigh_nxt = hwdata[7:0];
                REG_INT_EN:   intEn_nxt = hwdata[N_INT-1:0];
                REG_INT_FLAG: intFlag_nxt = intFlag_r & ~hwdata[N_INT-1:0];
                REG_STATUS:   ovf_nxt = ovf_r && !hwdata[STAT_OVF];
                REG_ACC:      acc_nxt = hwdata[7:0];
                REG_PM_ADDR:  pmAddr_nxt = hwdata[PC_W-1:0];
                REG_PM_DATA: begin
                    pmWe       = 1'b1;
                    pmAddr_nxt = pmAddr_r + 12'h001;
                end
                REG_CMD: begin
                    // A second command while one is queued is dropped
                    if (!cmdValid_r) begin
                        cmd_nxt.op   = psv_op_t'(hwdata[CMD_OP_LSB +: 4]);
                        cmd_nxt.arg  = hwdata[11:0];
                        cmdValid_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        case (state_r)
            ST_IDLE: begin
                if (canAck) begin
                    stkPush          = 1'b1;  // R19
                    pc_nxt           = VEC_TABLE[prioIdx];  // R7 R8 R9 R10 R11 R12
                    ackHot[prioIdx]  = 1'b1;
                    ctrl_nxt[CTRL_GIE] = 1'b0;
                    ack_nxt          = 1'b1;
                    ackIdx_nxt       = prioIdx;
                    state_nxt        = ST_BRANCH;
                end else if (cmdValid_r) begin
                    cmdValid_nxt = 1'b0;
                    pc_nxt       = pc_r + 12'h001;
                    case (cmd_r.op)
                        OP_JMP: begin
                            pc_nxt    = cmd_r.arg;
                            state_nxt = ST_BRANCH;
                        end
                        OP_CALL: begin
                            stkPush     = 1'b1;  // R3 R19
                            stkPushData = pc_r + 12'h001;
                            ovf_nxt     = ovf_nxt || stkFull;
                            pc_nxt      = cmd_r.arg;
                            state_nxt   = ST_BRANCH;
                        end
                        OP_RETURN, OP_INT_RETURN: begin
                            stkPop    = 1'b1;  // R2 R19
                            pc_nxt    = stkTop;
                            state_nxt = ST_BRANCH;
                            if (cmd_r.op == OP_INT_RETURN) begin
                                ctrl_nxt[CTRL_GIE] = 1'b1;
                            end
                        end
                        OP_LOAD_PC_LOW: begin
                            pc_nxt    = {pc_r[11:8], cmd_r.arg[7:0]};
                            state_nxt = ST_BRANCH;
                        end
                        OP_TBL_CUR, OP_TBL_LAST: begin
                            pc_nxt    = pc_r;
                            state_nxt = ST_TBL;  // R20
                        end
                        OP_ADD, OP_SUB: begin
                            aluSum = (cmd_r.op == OP_ADD)
                                   ? {1'b0, acc_r} + {1'b0, cmd_r.arg[7:0]}
                                   : {1'b0, acc_r} + {1'b0, ~cmd_r.arg[7:0]} + 9'h001;
                            // After a subtract, carry set means no borrow
                            acc_nxt   = aluSum[7:0];  // R4
                            carry_nxt = aluSum[8];
                            zero_nxt  = (aluSum[7:0] == 8'h00);
                        end
                        OP_AND, OP_OR, OP_XOR: begin
                            acc_nxt = (cmd_r.op == OP_AND) ? (acc_r & cmd_r.arg[7:0]) :
                                      (cmd_r.op == OP_OR)  ? (acc_r | cmd_r.arg[7:0]) :
                                                             (acc_r ^ cmd_r.arg[7:0]);
                            zero_nxt = (acc_nxt == 8'h00);  // R4
                        end
                        default: ;
                    endcase
                end
            end
            ST_BRANCH: state_nxt = ST_IDLE;
            ST_TBL: begin
                tblDest_nxt        = pmRdata[7:0];  // R16
                tableHighLatch_nxt = {1'b0, pmRdata[14:8]};
                pc_nxt             = pc_r + 12'h001;
                state_nxt          = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase

        // Hardware set wins over any clear in the same cycle
        intFlag_nxt = (intFlag_nxt & ~ackHot) | events;  // R1
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;          cmd_r <= '{op: OP_NOP, arg: 12'h000};
            cmdValid_r <= 1'b0;          pc_r <= VEC_RESET;  // R6
            acc_r <= 8'h00;              carry_r <= 1'b0;
            zero_r <= 1'b0;              tblLow_r <= 8'h00;
            tblHigh_r <= 8'h00;          tblDest_r <= 8'h00;
            tableHighLatch_r <= 8'h00;   intFlag_r <= '0;
            intEn_r <= '0;               ctrl_r <= CTRL_RESET;
            ovf_r <= 1'b0;               extPrev_r <= 1'b1;
            ack_r <= 1'b0;               ackIdx_r <= 3'h0;
            pmAddr_r <= 12'h000;
        end else begin
            state_r <= state_nxt;        cmd_r <= cmd_nxt;
            cmdValid_r <= cmdValid_nxt;  pc_r <= pc_nxt;
            acc_r <= acc_nxt;            carry_r <= carry_nxt;
            zero_r <= zero_nxt;          tblLow_r <= tblLow_nxt;
            tblHigh_r <= tblHigh_nxt;    tblDest_r <= tblDest_nxt;
            tableHighLatch_r <= tableHighLatch_nxt;
            intFlag_r <= intFlag_nxt;    intEn_r <= intEn_nxt;
            ctrl_r <= ctrl_nxt;          ovf_r <= ovf_nxt;
            extPrev_r <= extIntN;        ack_r <= ack_nxt;
            ackIdx_r <= ackIdx_nxt;      pmAddr_r <= pmAddr_nxt;
        end
    end

    assign pcOut       = pc_r;
    assign intAckPulse = ack_r;
    assign ackIndex    = ackIdx_r;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    psv_ret_stack u_stack (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .push     (stkPush),
        .pop      (stkPop),
        .pushData (stkPushData),
        .top      (stkTop),
        .level    (stkLevel),
        .full     (stkFull)
    );

    psv_prog_mem u_pmem (
        .sys_clk (sys_clk),
        .wrEn    (pmWe),
        .wrAddr  (pmAddr_r),
        .wrData  (hwdata[PM_W-1:0]),
        .rdAddr  (pmRaddr),
        .rdData  (pmRdata)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    logic idleCmd;
    assign idleCmd = (state_r == ST_IDLE) && !canAck && cmdValid_r;

    a_full_no_ack: assert property (stkFull && !stkPop |=> !ack_r) // R1
        else $error("acknowledge given with full stack");
    a_flag_kept: assert property (stkFull && usbIrq |=> intFlag_r[INT_USB]) // R1
        else $error("request flag lost while stack full");
    a_return_service: assert property (idleCmd && stkFull && |pending // R2
                                       && cmd_r.op inside {OP_RETURN, OP_INT_RETURN}
                                       && (ctrl_r[CTRL_GIE] || cmd_r.op == OP_INT_RETURN)
                                       |-> ##[2:3] ack_r)
        else $error("withheld interrupt not serviced after return");
    a_call_overflow: assert property (idleCmd && cmd_r.op == OP_CALL && stkFull
                                      |=> ovf_r && pc_r == $past(cmd_r.arg)) // R3
        else $error("call on full stack did not execute");
    a_alu_zero: assert property (idleCmd && cmd_r.op inside {OP_ADD, OP_SUB, OP_XOR}
                                 |=> zero_r == (acc_r == 8'h00)) // R4
        else $error("zero flag disagrees with result");
    a_reset_pc: assert property (@(posedge sys_clk) $rose(nrst) |-> pc_r == VEC_RESET) // R6
        else $error("program counter not at reset vector");
    a_vector_map: assert property (ack_r |-> pc_r == VEC_TABLE[ackIdx_r]) // R7 R8 R9 R10 R11 R12
        else $error("wrong interrupt vector");
    a_ext_edge: assert property ($fell(extIntN) |=> intFlag_r[INT_EXT]) // R8
        else $error("external falling edge not flagged");
    a_last_page: assert property (cmd_r.op == OP_TBL_LAST && !ctrl_r[CTRL_HP_EN]
                                  |-> pmRaddr == {LAST_PAGE, tblLow_r}) // R15
        else $error("last page address not forced");
    a_tbl_two: assert property (idleCmd && cmd_r.op inside {OP_TBL_CUR, OP_TBL_LAST}
                                |=> state_r == ST_TBL ##1 state_r == ST_IDLE) // R20
        else $error("table read not two cycles");
    a_tbl_high: assert property (state_r == ST_TBL |=> tableHighLatch_r
                                 == {1'b0, $past(pmRdata[14:8])}) // R16
        else $error("high latch wrong");
    a_prio_low: assert property (ack_r && $past(pending[0]) |-> ackIdx_r == 3'h0) // R21
        else $error("lower vector not taken first");

    c_int_ack:   cover property (ack_r);
    c_withheld:  cover property (stkFull && |pending && ctrl_r[CTRL_GIE]);
    c_tbl_read:  cover property (state_r == ST_TBL);
    c_call_ovf:  cover property ($rose(ovf_r));
endmodule

// *** tb/program_sequencer_vectors_test.sv ***
// Self-checking bench of the program sequencer: vectors, stack limits, table reads
module program_sequencer_vectors_test import psv_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, hreadyout, hresp, intAckPulse;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'hD;
    logic [1:0]  htrans = '0;
    logic [5:0]  src = '0;
    logic [11:0] pcOut;
    logic [2:0]  ackIndex;
    logic [3:0]  pg;
    logic [7:0]  lo;
    logic [14:0] w;
    logic [9:0]  ae;
    int          miscompares = 0, comparisons = 0, cyc = 0;
    bit          got;

    always #5 sys_clk = ~sys_clk;

    psv_sequencer dut_u (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .usbIrq(src[0]),
        .extIntN(~src[1]), .tmr0Ovf(src[2]), .serialIfaceADone(src[3]),
        .serialIfaceBDone(src[4]), .tmr1Ovf(src[5]), .pcOut(pcOut),
        .intAckPulse(intAckPulse), .ackIndex(ackIndex));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Mode 0 last page, 1 high pointer, 2 current page
    function automatic logic [11:0] tblAddr(int m, logic [3:0] p, logic [7:0] l);
        return {(m == 0) ? LAST_PAGE : p, l};
    endfunction

    // Zero, carry and result; after a subtract carry means no borrow
    function automatic logic [9:0] aluExp(bit sub, logic [7:0] a, logic [7:0] b);
        logic [7:0] r;
        r = sub ? a - b : a + b;
        return {r == 8'h00, sub ? a >= b : (9'(a) + 9'(b)) > 9'h0FF, r};
    endfunction

    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        comparisons++;
        if (got_v !== exp_v) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Fixed wait covers the two-cycle branch plus the queue slot
    task automatic cmd(input psv_op_t op, input logic [11:0] arg);
        bus(1'b1, REG_CMD, {12'h000, op, 4'h0, arg}, rd);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic pulse(input logic [5:0] m);
        src <= m;
        @(posedge sys_clk);
        src <= '0;
    endtask

    task automatic waitAck(output bit hit);
        hit = 0;
        for (int k = 0; k < 10 && !hit; k++) begin
            @(posedge sys_clk);
            hit = (intAckPulse === 1'b1);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        chk(pcOut, 0);
        bus(1'b0, REG_STATUS, 0, rd);
        chk({rd[10:8], hreadyout, hresp}, {3'd0, 2'b10});
        bus(1'b1, REG_INT_EN, 32'h3F, rd);
        for (int m = 0; m < 3; m++) begin
            pg = 4'(xs() % 15);
            lo = 8'(xs());
            w = 15'(xs());
            bus(1'b1, REG_PM_ADDR, 32'(tblAddr(m, pg, lo)), rd);
            bus(1'b1, REG_PM_DATA, 32'(w), rd);
            bus(1'b1, REG_CTRL, (m == 1) ? 32'h1 : 32'h0, rd);
            bus(1'b1, REG_TBL_LOW, 32'(lo), rd);
            bus(1'b1, REG_TBL_HIGH, 32'(pg), rd);
            if (m == 2)
                cmd(OP_JMP, {pg, 8'h10});
            cmd((m == 2) ? OP_TBL_CUR : OP_TBL_LAST, 12'h000);
            bus(1'b0, REG_TBL_RES, 0, rd);
            chk(rd, 32'(w));
            ae = aluExp(m != 1, lo, (m == 2) ? lo : w[7:0]);
            bus(1'b1, REG_ACC, 32'(lo), rd);
            cmd((m == 1) ? OP_ADD : OP_SUB, {4'h0, (m == 2) ? lo : w[7:0]});
            bus(1'b0, REG_STATUS, 0, rd);
            chk(rd[1:0], ae[9:8]);
            bus(1'b0, REG_ACC, 0, rd);
            chk(rd, 32'(ae[7:0]));
        end
        for (int i = 0; i < N_INT; i++) begin
            bus(1'b1, REG_CTRL, 32'h2, rd);
            pulse(6'h01 << i);
            waitAck(got);
            chk({got, ackIndex, pcOut}, {1'b1, 3'(i), VEC_TABLE[i]});
            cmd(OP_INT_RETURN, 12'h000);
        end
        bus(1'b1, REG_CTRL, 32'h0, rd);
        pulse(6'h36);
        bus(1'b1, REG_CTRL, 32'h2, rd);
        waitAck(got);
        chk({got, ackIndex}, {1'b1, 3'd1});
        bus(1'b1, REG_INT_FLAG, 32'h3F, rd);
        cmd(OP_INT_RETURN, 12'h000);
        for (int i = 0; i < STACK_DEPTH; i++)
            cmd(OP_CALL, 12'(12'h100 + i));
        bus(1'b0, REG_STATUS, 0, rd);
        chk({rd[10:8], rd[3]}, {3'd6, 1'b1});
        pulse(6'h04);
        waitAck(got);
        bus(1'b0, REG_INT_FLAG, 0, rd);
        chk({got, rd[2]}, 2'b01);
        cmd(OP_CALL, 12'h200);
        bus(1'b0, REG_STATUS, 0, rd);
        chk({rd[10:8], rd[4], rd[27:16]}, {3'd6, 1'b1, 12'h200});
        bus(1'b1, REG_CMD, {12'h000, OP_RETURN, 16'h0000}, rd);
        waitAck(got);
        chk({got, pcOut}, {1'b1, 12'h00C});
        stop_test();
    end
endmodule
